/* hw/adc_dev_end.sv */
// Purpose: converter sequencer: frames, configuration, result store, triggers
// Assumes: link pins come from the host and are synchronised here
// Notes:   sampleData stands in for the analog result of sampleChannel
// Summary of operation
// - configuration write loads settings, clears store and flags
// - in store modes, first command after interrupt means drain
// - oldest entry leaves before command decoding
// - non-drain command stops started output
// - drain never converts nor signals
// - unread entries dropped when draining stops
// - conversion clock: oscillator or serial clock/4
// - eighteen or thirteen clocks plus 15 ns
// - four conversion modes, two non-conversion operations
// - one-shot select frame returns result, converts unless the start pin has triggered
// - one-shot start pin overwrites unread result
// - host selects channel after drain
// - repeat start pin overwrites old group
// - host arms before sweep start pulse
// - host drains or reconfigures after sweep
// - repeat sweep trigger overwrites without drain
// - end-of-conversion low during, interrupt after
// - eight entries, threshold interrupt, cleared on configuration
// - result left-justified in sixteen bits
`timescale 1ns/10ps
module adc_dev_end (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    adc_link_if.dev                        link,
    input  wire logic [adc_seq_pkg::SAMPLE_W-1:0] sampleData,
    output logic [2:0]                     sampleChannel,
    output logic                           sampleTake,
    output logic [adc_seq_pkg::CFG_W-1:0]  configWord,
    output logic [3:0]                     fifoLevel
);
    import adc_seq_pkg::*;

    typedef enum logic [1:0] {LINK_IDLE, LINK_CMD, LINK_DATA} link_state_t;

    link_state_t       linkState;
    logic [4:0]        pinS1, pinS2, pinS3;
    logic              sclkRise, sclkFall, frameStart, startRise;
    logic [4:0]        bitCnt;
    logic [WORD_W-1:0] rxShift, txShift, resultWord;
    logic [3:0]        cmd;
    logic              cmdDecoded, frameEnd;
    logic              drainFrame, draining, groupDone, armed, pinTriggered;
    logic              fifoMode, convStart, convBusy, convDone, trigAccept;
    logic              selTrig, pinTrig, pushNow, popNow, flushNow;
    logic [WORD_W-1:0] fifoMem [FIFO_DEPTH];
    logic [2:0]        rdPtr, wrPtr;
    logic [3:0]        count;
    conv_mode_t        mode;

    assign mode     = conv_mode_t'(configWord[CFG_MODE_LSB +: 2]);
    assign fifoMode = (mode != MODE_ONE_SHOT);

    // pins pass two flops; the third only feeds edge detection
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pinS1 <= 5'h1e;
            pinS2 <= 5'h1e;
            pinS3 <= 5'h1e;
        end else begin
            pinS1 <= {link.serialDataIn, link.conversionStartN, link.frameSync,
                      link.csN, link.sclk};
            pinS2 <= pinS1;
            pinS3 <= pinS2;
        end
    end

    assign sclkRise   = pinS2[0] && !pinS3[0];
    assign sclkFall   = !pinS2[0] && pinS3[0];
    assign frameStart = (!pinS2[1] && pinS3[1]) || (pinS2[2] && !pinS3[2] && !pinS2[1]);
    assign startRise  = pinS2[3] && !pinS3[3];
    // the fourth bit is still on the pin at decode; at frame end the code sits above the data
    assign cmd        = (linkState == LINK_CMD) ? {rxShift[CMD_W-2:0], pinS2[4]}
                                                : rxShift[WORD_W-2 -: CMD_W];
    assign cmdDecoded = (linkState == LINK_CMD) && sclkRise && bitCnt == CMD_BITS - 5'h01;
    assign frameEnd   = (linkState == LINK_DATA) && sclkRise && bitCnt == FRAME_BITS - 5'h01;
    // in a store mode, a frame while the interrupt stands or a drain runs, with entries stored, is a drain frame
    assign drainFrame = fifoMode && (!link.intN || draining) && count != 4'h0;

    // frame sequencing
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            linkState <= LINK_IDLE;
            bitCnt    <= 5'h00;
            rxShift   <= '0;
        end else begin
            if (frameStart) begin
                linkState <= LINK_CMD;
                bitCnt    <= 5'h00;
            end else if (sclkRise && linkState != LINK_IDLE) begin
                rxShift <= {rxShift[WORD_W-2:0], pinS2[4]};
                bitCnt  <= bitCnt + 5'h01;
                unique case (linkState)
                    LINK_CMD:  linkState <= cmdDecoded ? LINK_DATA : LINK_CMD;
                    LINK_DATA: linkState <= frameEnd ? LINK_IDLE : LINK_DATA;
                    LINK_IDLE: linkState <= LINK_IDLE;
                endcase
            end
        end
    end

    // output shifter; drain data leaves before the command is known
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            txShift              <= '0;
            link.serialDataOutOe <= 1'b0;
        end else if (frameStart) begin
            txShift              <= drainFrame ? fifoMem[rdPtr] : resultWord;
            link.serialDataOutOe <= 1'b1;
        end else if (cmdDecoded && (drainFrame || draining) && cmd != CMD_FIFO_READ) begin
            link.serialDataOutOe <= 1'b0;
        end else if (frameEnd) begin
            link.serialDataOutOe <= 1'b0;
        end else if (sclkFall && linkState != LINK_IDLE) begin
            txShift <= {txShift[WORD_W-2:0], 1'b0};
        end
    end
    assign link.serialDataOut = txShift[WORD_W-1];

    // configuration, loaded only by its own frame
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            configWord <= CFG_RESET;
        end else if (frameEnd && cmd == CMD_CFG_WRITE) begin
            configWord <= {rxShift[CFG_W-2:0], pinS2[4]};
        end
    end

    // conversion triggers: select frame end or start pin rise
    assign selTrig = frameEnd && !cmd[CMD_W-1]
                     && !(mode == MODE_ONE_SHOT && pinTriggered);
    assign pinTrig = startRise && (!configWord[CFG_MODE_LSB + 1] || armed);
    // a finished sweep waits for a drain or configuration
    assign trigAccept = !convBusy && !(mode == MODE_SWEEP && groupDone);
    assign convStart  = (selTrig || pinTrig) && trigAccept;
    assign pushNow    = convDone && fifoMode;
    assign popNow     = frameEnd && cmd == CMD_FIFO_READ && drainFrame;
    // a new group after a finished one overwrites the store
    assign flushNow   = (frameEnd && cmd == CMD_CFG_WRITE)
                        || (convStart && fifoMode && groupDone)
                        || (cmdDecoded && draining && cmd != CMD_FIFO_READ);

    conv_timer u_timer (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (convStart),
        .extClk   (configWord[CFG_EXT_CLK_BIT]),
        .shortRes (configWord[CFG_SHORT_RES_BIT]),
        .sclkRise (sclkRise),
        .busy     (convBusy),
        .done     (convDone)
    );

    // channel follows a select that opens a group
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sampleChannel <= 3'h0;
        end else if (selTrig && trigAccept && (!fifoMode || count == 4'h0 || groupDone)) begin
            sampleChannel <= cmd[2:0];
        end
    end

    // one-shot result; a new conversion overwrites an unread one
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            resultWord <= '0;
        end else if (convDone && !fifoMode) begin
            resultWord <= outputWord(sampleData, configWord[CFG_SHORT_RES_BIT]);
        end
    end

    // result store
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdPtr <= 3'h0;
            wrPtr <= 3'h0;
            count <= 4'h0;
        end else if (flushNow) begin
            rdPtr <= 3'h0;
            wrPtr <= 3'h0;
            count <= 4'h0;
        end else begin
            if (pushNow) begin
                fifoMem[wrPtr] <= outputWord(sampleData, configWord[CFG_SHORT_RES_BIT]);
                wrPtr          <= wrPtr + 3'h1;
            end
            if (popNow) begin
                rdPtr <= rdPtr + 3'h1;
            end
            count <= count + {3'h0, pushNow} - {3'h0, popNow};
        end
    end

    // group, drain and arm bookkeeping
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            groupDone    <= 1'b0;
            draining     <= 1'b0;
            armed        <= 1'b0;
            pinTriggered <= 1'b0;
        end else begin
            if (frameEnd && cmd == CMD_CFG_WRITE) begin
                groupDone    <= 1'b0;
                draining     <= 1'b0;
                armed        <= 1'b0;
                pinTriggered <= 1'b0;
            end else begin
                if (pushNow && count + 4'h1 == thresholdCount(configWord[1:0])) begin
                    groupDone <= 1'b1;
                end else if (flushNow || (popNow && count == 4'h1)) begin
                    groupDone <= 1'b0;
                end
                if (popNow) begin
                    draining <= (count != 4'h1);
                    armed    <= armed && (count != 4'h1);
                end else if (flushNow) begin
                    draining <= 1'b0;
                end else if (frameStart && drainFrame) begin
                    draining <= 1'b1;
                end
                if (selTrig) begin
                    armed <= 1'b1;
                end
                if (pinTrig) begin
                    pinTriggered <= 1'b1;
                end
            end
        end
    end

    // end-of-conversion and interrupt pins; a frame start or start pin rise releases the interrupt unless a new one is raised in the same cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            link.eocN  <= 1'b1;
            link.intN  <= 1'b1;
            sampleTake <= 1'b0;
        end else begin
            link.eocN  <= !(convBusy || convStart);
            sampleTake <= convDone;
            if ((convDone && !fifoMode)
                || (pushNow && count + 4'h1 == thresholdCount(configWord[1:0]))) begin
                link.intN <= 1'b0;
            end else if (frameStart || startRise) begin
                link.intN <= 1'b1;
            end
        end
    end

    assign fifoLevel = count;
endmodule // adc_dev_end

/* hw/adc_host_end.sv */
// Purpose: host serial port driving the sequencer, ordered over classic Wishbone
// Assumes: single-cycle classic Wishbone master, 32-bit data
// Notes:   serial clock is core_clk divided by twice SCLK_HALF_CYC
`timescale 1ns/10ps
module adc_host_end (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    adc_link_if.host         link,
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [3:0]  adr,
    input  wire logic [3:0]  sel,
    input  wire logic [31:0] datW,
    output logic [31:0]      datR,
    output logic             ack
);
    import adc_seq_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_LEAD, H_BITS} host_state_t;

    host_state_t       state;
    logic [2:0]        halfCnt, startCnt;
    logic [4:0]        bitCnt;
    logic [WORD_W-1:0] txShift, rxShift, rxWord;
    logic              useFrameSync, halfEnd, wrStrobe;
    logic [2:0]        inS1, inS2;

    assign halfEnd  = (halfCnt == SCLK_HALF_CYC - 3'h1);
    assign wrStrobe = cyc && stb && we && ack && sel[0];

    // device pins pass two flops
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            inS1 <= 3'h7;
            inS2 <= 3'h7;
        end else begin
            inS1 <= {link.serialDataOut, link.eocN, link.intN};
            inS2 <= inS1;
        end
    end

    // bus answer one cycle after the request, held for one cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ack  <= 1'b0;
            datR <= 32'h0;
        end else begin
            ack <= cyc && stb && !ack;
            unique case (adr)
                REG_STATUS: datR <= {29'h0, inS2[1], inS2[0], state != H_IDLE};
                REG_RX:     datR <= {16'h0, rxWord};
                default:    datR <= 32'h0;
            endcase
        end
    end

    // start pin pulse
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            startCnt              <= 3'h0;
            link.conversionStartN <= 1'b1;
        end else if (wrStrobe && adr == REG_START) begin
            startCnt              <= START_LOW_CYC;
            link.conversionStartN <= 1'b0;
        end else if (startCnt != 3'h0) begin
            startCnt              <= startCnt - 3'h1;
            link.conversionStartN <= (startCnt == 3'h1);
        end
    end

    // frame engine: lead period, then sixteen serial clocks
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state             <= H_IDLE;
            halfCnt           <= 3'h0;
            bitCnt            <= 5'h00;
            txShift           <= '0;
            rxShift           <= '0;
            rxWord            <= '0;
            useFrameSync      <= 1'b0;
            link.sclk         <= 1'b0;
            link.csN          <= 1'b1;
            link.frameSync    <= 1'b0;
            link.serialDataIn <= 1'b1;
        end else begin
            halfCnt <= (state == H_IDLE || halfEnd) ? 3'h0 : halfCnt + 3'h1;
            unique case (state)
                H_IDLE: begin
                    if (wrStrobe && adr == REG_CMD) begin
                        state             <= H_LEAD;
                        txShift           <= datW[WORD_W-1:0];
                        useFrameSync      <= datW[CMD_FRAME_SYNC_BIT];
                        link.csN          <= 1'b0; // select stays low in frame-sync frames too
                        link.frameSync    <= datW[CMD_FRAME_SYNC_BIT];
                        link.serialDataIn <= datW[WORD_W-1];
                        bitCnt            <= 5'h00;
                    end
                end
                H_LEAD: begin
                    if (halfEnd) begin
                        state          <= H_BITS;
                        link.frameSync <= 1'b0;
                        link.csN       <= 1'b0;
                    end
                end
                H_BITS: begin
                    if (halfEnd && !link.sclk) begin
                        link.sclk <= 1'b1;
                    end else if (halfEnd) begin
                        link.sclk         <= 1'b0;
                        rxShift           <= {rxShift[WORD_W-2:0], inS2[2]};
                        txShift           <= {txShift[WORD_W-2:0], 1'b0};
                        link.serialDataIn <= txShift[WORD_W-2];
                        bitCnt            <= bitCnt + 5'h01;
                        if (bitCnt == FRAME_BITS - 5'h01) begin
                            state             <= H_IDLE;
                            rxWord            <= {rxShift[WORD_W-2:0], inS2[2]};
                            link.csN          <= 1'b1;
                            link.serialDataIn <= 1'b1;
                        end
                    end
                end
                default: state <= H_IDLE;
            endcase
            if (state == H_IDLE && useFrameSync) begin
                useFrameSync <= 1'b0;
            end
        end
    end
endmodule // adc_host_end

/* hw/adc_link_if.sv */
// Purpose: serial link between host port and converter sequencer
// Assumes: host makes every clock, select and start signal
// Notes:   serialDataOut is always driven; the host end reads it directly, and the enable only feeds the assertions
`timescale 1ns/10ps
interface adc_link_if;
    logic sclk;
    logic csN;
    logic frameSync;
    logic conversionStartN;
    logic serialDataIn;
    logic serialDataOut;
    logic serialDataOutOe;
    logic eocN;
    logic intN;

    modport dev (
        input  sclk, csN, frameSync, conversionStartN, serialDataIn,
        output serialDataOut, serialDataOutOe, eocN, intN
    );
    modport host (
        output sclk, csN, frameSync, conversionStartN, serialDataIn,
        input  serialDataOut, serialDataOutOe, eocN, intN
    );
endinterface // adc_link_if

/* hw/adc_seq_pkg.sv */
// Purpose: shared constants and types of the converter sequencer and its host
// Assumes: core_clk at 100 MHz, one clock domain on both ends
// Notes:   byte addresses of the host command registers sit here too
package adc_seq_pkg;
    localparam int CMD_W      = 4;
    localparam int CFG_W      = 12;
    localparam int WORD_W     = 16;
    localparam int SAMPLE_W   = 14;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_BITS   = 5'h04;

    // command codes; codes 0..7 select a channel
    localparam logic [3:0] CMD_CFG_WRITE = 4'ha;
    localparam logic [3:0] CMD_FIFO_READ = 4'he;

    // configuration word fields
    localparam int CFG_THR_LSB       = 0;
    localparam int CFG_MODE_LSB      = 5;
    localparam int CFG_EXT_CLK_BIT   = 7;
    localparam int CFG_SHORT_RES_BIT = 8;
    localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

    // conversion timing
    localparam logic [4:0] CONV_CLKS_14       = 5'h12;
    localparam logic [4:0] CONV_CLKS_12       = 5'h0d;
    localparam logic [1:0] SCLK_PER_CONV_LAST = 2'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TAIL_NS  = 15;
    localparam logic [1:0] CONV_TAIL_CYC =
        2'((CONV_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int CORE_KHZ    = 100000;
    localparam int INT_OSC_KHZ = 6500;
    localparam logic [3:0] INT_OSC_DIV = 4'(CORE_KHZ / INT_OSC_KHZ);

    // host link timing
    localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
    localparam logic [2:0] START_LOW_CYC = 3'h4;

    // host register byte addresses
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_START  = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_RX     = 4'hc;
    localparam int CMD_FRAME_SYNC_BIT = 16;

    typedef enum logic [1:0] {
        MODE_ONE_SHOT   = 2'h0,
        MODE_REPEAT     = 2'h1,
        MODE_SWEEP      = 2'h2,
        MODE_REP_SWEEP  = 2'h3
    } conv_mode_t;

    // threshold code to number of stored results
    function automatic logic [3:0] thresholdCount(input logic [1:0] code);
        case (code)
            2'h0:    return 4'h8;
            2'h1:    return 4'h6;
            2'h2:    return 4'h4;
            default: return 4'h2;
        endcase
    endfunction

    // result left-justified in the output word, low bits zero
    function automatic logic [WORD_W-1:0] outputWord(input logic [SAMPLE_W-1:0] s,
                                                     input logic shortRes);
        return shortRes ? {s[SAMPLE_W-1:2], 4'h0} : {s, 2'h0};
    endfunction
endpackage

/* hw/conv_timer.sv */
// Purpose: counts conversion clocks plus the closing delay of one conversion
// Assumes: sclkRise is a one-cycle pulse from synchronised pins
// Notes:   the internal oscillator is a free divider of core_clk
`timescale 1ns/10ps
module conv_timer (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic start,
    input  wire logic extClk,
    input  wire logic shortRes,
    input  wire logic sclkRise,
    output logic      busy,
    output logic      done
);
    import adc_seq_pkg::*;

    logic [3:0] oscCnt;
    logic [1:0] sclkCnt;
    logic [4:0] clkCnt;
    logic [1:0] tailCnt;
    logic       inTail;
    logic       convTick;
    logic [4:0] lastClk;

    // internal oscillator tick or every fourth serial clock
    assign convTick = extClk ? (sclkRise && sclkCnt == SCLK_PER_CONV_LAST)
                             : (oscCnt == INT_OSC_DIV - 4'h1);
    assign lastClk  = (shortRes ? CONV_CLKS_12 : CONV_CLKS_14) - 5'h01;

    // free running oscillator divider
    always_ff @(posedge core_clk) begin
        if (!nrst || oscCnt == INT_OSC_DIV - 4'h1) begin
            oscCnt <= 4'h0;
        end else begin
            oscCnt <= oscCnt + 4'h1;
        end
    end

    // conversion clock count, then the closing delay
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busy    <= 1'b0;
            done    <= 1'b0;
            inTail  <= 1'b0;
            clkCnt  <= 5'h00;
            sclkCnt <= 2'h0;
            tailCnt <= 2'h0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy    <= 1'b1;
                inTail  <= 1'b0;
                clkCnt  <= 5'h00;
                sclkCnt <= 2'h0;
                tailCnt <= 2'h0;
            end else if (busy && !inTail) begin
                if (sclkRise) begin
                    sclkCnt <= sclkCnt + 2'h1;
                end
                if (convTick) begin
                    if (clkCnt == lastClk) begin
                        inTail <= 1'b1;
                    end else begin
                        clkCnt <= clkCnt + 5'h01;
                    end
                end
            end else if (inTail) begin
                tailCnt <= tailCnt + 2'h1;
                if (tailCnt == CONV_TAIL_CYC - 2'h1) begin
                    busy   <= 1'b0;
                    inTail <= 1'b0;
                    done   <= 1'b1;
                end
            end
        end
    end
endmodule // conv_timer

/* verification/adc_conversion_sequencer_test.sv */
// Purpose: bench for host and device ends joined by the link
// Assumes: internal conversion clock
// Notes:   a queue model predicts every stored word drained; one-shot reads are checked against the last result
`timescale 1ns/10ps
module adc_conversion_sequencer_test;
    import adc_seq_pkg::*;
    logic        core_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, ack, have;
    logic [3:0]  adr = 4'h0, level;
    logic [11:0] cw, cfg;
    logic [13:0] sample = 14'h0000;
    logic [15:0] last, q[$];
    logic [31:0] datW = 32'h0, datR, r, seed = 32'h2241f5ae;
    logic [2:0]  chan;
    int          n_mismatch = 0, checks_done = 0, cycles = 0, thr;
    logic [11:0] cfgs[7] = '{12'h000, 12'h100, 12'h000, 12'h023, 12'h022, 12'h043, 12'h063};
    logic [6:0]  starts = 7'h34, drains = 7'h28;
    adc_link_if link ();
    adc_dev_end u_adc_dev_end (.core_clk(core_clk), .nrst(nrst), .link(link),
        .sampleData(sample), .sampleChannel(chan), .sampleTake(), .configWord(cw),
        .fifoLevel(level));
    adc_host_end u_adc_host_end (.core_clk(core_clk), .nrst(nrst), .link(link), .cyc(cyc),
        .stb(cyc), .we(we), .adr(adr), .sel(4'hf), .datW(datW), .datR(datR), .ack(ack));
    adc_seq_sva u_adc_seq_sva (.core_clk(core_clk), .nrst(nrst), .sclk(link.sclk),
        .csN(link.csN), .frameSync(link.frameSync),
        .conversionStartN(link.conversionStartN), .serialDataOutOe(link.serialDataOutOe),
        .eocN(link.eocN), .intN(link.intN));
    // clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        while (ack !== 1'b1) @(posedge core_clk);
        r = datR;
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask
    // one link frame, then the received word
    task automatic frame(input logic [3:0] c, input logic [11:0] d, input logic fs);
        wb(1'b1, REG_CMD, {15'h0000, fs, c, d});
        do wb(1'b0, REG_STATUS, 32'h0); while (r[0] !== 1'b0);
        wb(1'b0, REG_RX, 32'h0);
    endtask
    task automatic conv();
        int n = 0;
        for (int k = 0; k < 800 && n < 2; k++) begin
            @(posedge core_clk);
            if (link.eocN === (n != 0)) n++;
        end
        repeat (3) @(posedge core_clk);
        chk(32'(n), 32'h2);
    endtask
    // one trigger, its conversion and the model update
    task automatic grp(input logic st);
        logic [13:0] s = 14'(rnd());
        logic [2:0]  c = 3'(rnd());
        sample <= s;
        if (st) wb(1'b1, REG_START, 32'h0);
        else frame({1'b0, c}, 12'h000, seed[9]);
        if (!st && cfg[6:5] == 2'h0 && have) chk(r[15:0], last);
        conv();
        if (cfg[6:5] == 2'h0) begin
            last = cfg[8] ? {s[13:2], 4'h0} : {s, 2'h0};
            have = 1'b1;
            if (!st) chk(chan, c);
        end else begin
            if (q.size() >= thr) q.delete();
            q.push_back(cfg[8] ? {s[13:2], 4'h0} : {s, 2'h0});
        end
        chk(link.intN, cfg[6:5] != 2'h0 && q.size() < thr);
    endtask
    task automatic drain();
        chk(level, q.size());
        while (q.size() > 0) begin
            frame(CMD_FIFO_READ, 12'h000, 1'b0);
            chk(r[15:0], q.pop_front());
        end
        chk(level, 4'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        wb(1'b0, REG_STATUS, 32'h0);
        chk({level, r[2:0]}, 7'h06);
        wb(1'b1, 4'h2, 32'hffffffff);
        wb(1'b0, 4'h2, 32'h0);
        chk(r, 32'h0);
        for (int i = 0; i < 7; i++) begin
            cfg = cfgs[i];
            frame(CMD_CFG_WRITE, cfg, 1'b0);
            q.delete();
            have = 1'b0;
            repeat (4) @(posedge core_clk);
            chk({cw, level, link.eocN, link.intN}, {cfg, 6'h03});
            thr = cfg[6:5] == 2'h0 ? 2 : 8 - 2 * cfg[1:0];
            repeat (2) begin
                repeat (thr) grp(starts[i] && !(cfg[6] && q.size() == 0));
                if (drains[i]) drain();
            end
            if (cfg[6:5] == 2'h0 && starts[i]) begin
                frame(4'h1, 12'h000, 1'b0);
                chk(r[15:0], last);
            end
            drain();
            $display("test %0d done", i);
        end
        tally_and_finish();
    end
endmodule // adc_conversion_sequencer_test

/* verification/adc_seq_sva.sv */
// Purpose: link checks for the sequencer pair
// Assumes: one clock, nrst sync active low
// Notes:   watches the interface signals only
`timescale 1ns/10ps
module adc_seq_sva (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic frameSync,
    input wire logic conversionStartN,
    input wire logic serialDataOutOe,
    input wire logic eocN,
    input wire logic intN
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [9:0] lowRun;
    // length of the running conversion
    always_ff @(posedge core_clk) begin
        if (!nrst || eocN) lowRun <= 10'h000;
        else if (lowRun != 10'h3ff) lowRun <= lowRun + 10'h001;
    end
    chk_conv_min_len: assert property ($rose(eocN) |-> lowRun >= 10'h0b4)
        else $error("conversion too short");
    chk_int_not_busy: assert property (!eocN |-> intN)
        else $error("interrupt during conversion");
    chk_int_after_conv: assert property ($fell(intN) |-> eocN)
        else $error("interrupt without finished conversion");
    chk_oe_in_frame: assert property ($rose(serialDataOutOe) |-> !csN)
        else $error("output enabled outside a frame");
    chk_oe_idle: assert property (csN [*8] |-> !serialDataOutOe)
        else $error("output left driving");
    chk_fs_pulse: assert property ($rose(frameSync) |-> !csN ##[3:5] !frameSync)
        else $error("bad frame sync pulse");
    chk_start_pulse: assert property ($fell(conversionStartN) |->
        !conversionStartN [*3] ##[1:2] conversionStartN) else $error("bad start pulse");
    chk_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("bad serial clock high phase");
endmodule // adc_seq_sva
